/* File: ssp_pkg.sv */
// constants, register map and carrier types of the serial port block
// assumes an APB master on the core clock and a core that polls or takes the irq line
package ssp_pkg;
   localparam int ADDR_W = 12;
   // printed offsets are register indices; byte address is four times them
   localparam logic [9:0] IDX_DATA = 10'h07F;
   localparam logic [9:0] IDX_CTRL = 10'h0F8;
   localparam logic [9:0] IDX_IE = 10'h000;
   localparam logic [7:0] CTRL_RST = 8'h05;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam int B_DONE = 7;
   localparam int B_WRITE_COLLISION_FLAG = 6;
   localparam int B_IE = 0;
   localparam int PIN_SCLK = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_MISO = 2;
   localparam int PIN_SEL = 3;
   localparam int PIN_N = 4;

   typedef struct packed {
      logic done;
      logic write_collision_flag;
      logic en;
      logic master;
      logic clock_idle_polarity;
      logic clock_phase_select;
      logic [1:0] rate;
   } ssp_ctrl_t;

   typedef struct packed {
      logic [PIN_N-1:0] o;
      logic [PIN_N-1:0] oe;
   } ssp_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MRUN,
      ST_SRUN
   } ssp_state_t;
endpackage : ssp_pkg

/* File: ssp_port.sv */
// byte-wide serial peripheral port, master and slave, with APB register access
// assumes pins are resolved outside from o/oe; general-purpose port logic supplies GP_O/GP_OE
//
// Register access over APB was left to the implementer.
module ssp_port import ssp_pkg::*; #(
   parameter int BYTE_BITS = 8
) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [PIN_N-1:0] PIN_I,
   output logic [PIN_N-1:0] PIN_O,
   output logic [PIN_N-1:0] PIN_OE,
   input wire logic [PIN_N-1:0] GP_O,
   input wire logic [PIN_N-1:0] GP_OE,
   output logic [PIN_N-1:0] GP_I,
   input wire logic I2C_IRQ,
   output logic IRQ
);
   localparam int CW = $clog2(2 * BYTE_BITS + 1);

   // shift path and byte assembly are written for eight bits only
   if (BYTE_BITS != 8) begin : g_width_chk
      $error("serial port shifts whole bytes only");
   end

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction : hit

   ssp_ctrl_t ctrl_ff;
   ssp_state_t state_ff;
   ssp_pins_t pins_ff;
   logic [7:0] data_ff;
   logic [7:0] sh_ff;
   logic ie_ff;
   logic out_bit_ff;
   logic rx_bit_ff;
   logic sclk_ff;
   logic [3:0] div_ff;
   logic [CW-1:0] edge_ff;
   logic [PIN_N-1:0] sync1_ff;
   logic [PIN_N-1:0] sync2_ff;
   logic sclk_prev_ff;
   logic sel_prev_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic irq_ff;

   // two-stage synchronisers; only the second stage is read
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         always_ff @(posedge MCLK) begin
            if (SYS_RST) begin
               sync1_ff[gi] <= 1'b1;
               sync2_ff[gi] <= 1'b1;
            end else begin
               sync1_ff[gi] <= PIN_I[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   // apb access decode
   logic acc, wr_en, rd_en, sel_data, sel_ctrl, sel_ie, mapped;
   assign acc = PSEL && PENABLE && pready_ff;
   assign wr_en = acc && PWRITE;
   assign rd_en = acc && !PWRITE;
   assign sel_data = hit(PADDR, IDX_DATA);
   assign sel_ctrl = hit(PADDR, IDX_CTRL);
   assign sel_ie = hit(PADDR, IDX_IE);
   assign mapped = sel_data || sel_ctrl || sel_ie;

   logic busy, data_wr, data_rd, ctrl_wr;
   assign data_wr = wr_en && sel_data;
   assign data_rd = rd_en && sel_data;
   assign ctrl_wr = wr_en && sel_ctrl;

   // slave link events from synchronised pins
   logic s_sclk, s_sel_n, s_mosi, s_miso;
   logic s_edge, s_lead, s_trail, sel_rise;
   assign s_sclk = sync2_ff[PIN_SCLK];
   assign s_sel_n = sync2_ff[PIN_SEL];
   assign s_mosi = sync2_ff[PIN_MOSI];
   assign s_miso = sync2_ff[PIN_MISO];
   assign s_edge = (s_sclk != sclk_prev_ff) && !s_sel_n;
   assign s_lead = s_edge && (sclk_prev_ff == ctrl_ff.clock_idle_polarity);
   assign s_trail = s_edge && (sclk_prev_ff != ctrl_ff.clock_idle_polarity);
   assign sel_rise = s_sel_n && !sel_prev_ff;

   // master half-period tick from the rate divider
   logic [3:0] half_m1;
   logic tick;
   assign half_m1 = 4'((5'h01 << ctrl_ff.rate) - 5'h01);
   assign tick = (state_ff == ST_MRUN) && (div_ff == half_m1);

   // unified edge roles for both modes
   logic lead, trail, rx_in;
   assign lead = (state_ff == ST_MRUN) ? (tick && !edge_ff[0]) : (state_ff == ST_SRUN && s_lead);
   assign trail = (state_ff == ST_MRUN) ? (tick && edge_ff[0]) : (state_ff == ST_SRUN && s_trail);
   assign rx_in = ctrl_ff.master ? s_miso : s_mosi;

   logic m_done, s_done, xfer_done;
   assign m_done = tick && (edge_ff == CW'(2 * BYTE_BITS - 1));
   // phase 1 ends on the eighth trailing edge, phase 0 on select release
   assign s_done = (state_ff == ST_SRUN) &&
      (ctrl_ff.clock_phase_select ? (s_trail && edge_ff == CW'(2 * BYTE_BITS - 1)) :
       (sel_rise && edge_ff == CW'(2 * BYTE_BITS)));
   assign xfer_done = m_done || s_done;
   assign busy = (state_ff == ST_MRUN) || (state_ff == ST_SRUN && edge_ff != '0);

   // transfer sequencing
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (ctrl_ff.en && ctrl_ff.master && data_wr) begin
                  state_ff <= ST_MRUN;
               end else if (ctrl_ff.en && !ctrl_ff.master) begin
                  state_ff <= ST_SRUN;
               end
            end
            ST_MRUN: begin
               if (m_done || !ctrl_ff.en) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_SRUN: begin
               if (s_done || !ctrl_ff.en || ctrl_ff.master) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // divider and edge counter; select pin plays no part in master mode
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         div_ff <= 4'h0;
         edge_ff <= '0;
      end else if (state_ff == ST_MRUN) begin
         div_ff <= tick ? 4'h0 : div_ff + 4'h1;
         if (tick) begin
            edge_ff <= edge_ff + CW'(1);
         end
      end else if (state_ff == ST_SRUN) begin
         div_ff <= 4'h0;
         if (s_sel_n && ctrl_ff.clock_phase_select) begin
            edge_ff <= edge_ff;
         end else if (s_done || (s_sel_n && !sel_rise)) begin
            edge_ff <= '0;
         end else if (s_edge) begin
            edge_ff <= (edge_ff == CW'(2 * BYTE_BITS)) ? CW'(1) : edge_ff + CW'(1);
         end
      end else begin
         div_ff <= 4'h0;
         edge_ff <= '0;
      end
   end

   // master clock level, idle at polarity between bursts
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         sclk_ff <= 1'b0;
      end else if (state_ff == ST_MRUN) begin
         if (tick) begin
            sclk_ff <= !sclk_ff;
         end
      end else begin
         sclk_ff <= ctrl_ff.clock_idle_polarity;
      end
   end

   // shift path, msb first; phase picks which edge shifts and which samples
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         sh_ff <= DATA_RST;
         out_bit_ff <= 1'b0;
         rx_bit_ff <= 1'b0;
      end else if (data_wr && !busy) begin
         sh_ff <= PWDATA[7:0];
         out_bit_ff <= PWDATA[7];
      end else if (ctrl_ff.clock_phase_select) begin
         if (lead) begin
            out_bit_ff <= sh_ff[7];
         end
         if (trail) begin
            sh_ff <= {sh_ff[6:0], rx_in};
         end
      end else begin
         if (lead) begin
            rx_bit_ff <= rx_in;
         end
         if (trail) begin
            sh_ff <= {sh_ff[6:0], rx_bit_ff};
            out_bit_ff <= sh_ff[6];
         end
      end
   end

   // received byte lands in the data register only at completion
   logic [7:0] rx_byte;
   assign rx_byte = (ctrl_ff.clock_phase_select || m_done) ? {sh_ff[6:0], rx_in} : sh_ff;
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         data_ff <= DATA_RST;
      end else if (xfer_done) begin
         data_ff <= (ctrl_ff.clock_phase_select || !ctrl_ff.master) ? rx_byte :
                    {sh_ff[6:0], rx_bit_ff};
      end else if (data_wr && !busy) begin
         data_ff <= PWDATA[7:0];
      end
   end

   // control register; hardware sets win over software clears
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ctrl_ff <= ssp_ctrl_t'(CTRL_RST);
      end else begin
         if (ctrl_wr) begin
            ctrl_ff.en <= PWDATA[5];
            ctrl_ff.master <= PWDATA[4];
            ctrl_ff.clock_idle_polarity <= PWDATA[3];
            ctrl_ff.clock_phase_select <= PWDATA[2];
            ctrl_ff.rate <= PWDATA[1:0];
         end
         if (xfer_done) begin
            ctrl_ff.done <= 1'b1;
         end else if (data_rd || (ctrl_wr && !PWDATA[B_DONE])) begin
            ctrl_ff.done <= 1'b0;
         end
         if (data_wr && busy) begin
            ctrl_ff.write_collision_flag <= 1'b1;
         end else if (ctrl_wr && !PWDATA[B_WRITE_COLLISION_FLAG]) begin
            ctrl_ff.write_collision_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ie_ff <= 1'b0;
      end else if (wr_en && sel_ie) begin
         ie_ff <= PWDATA[B_IE];
      end
   end

   // apb answer one cycle into the access phase
   logic [7:0] ctrl_rd;
   assign ctrl_rd = {ctrl_ff[7:1], ctrl_ff.master ? ctrl_ff.rate[0] : s_sel_n};
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= PSEL && PENABLE && !pready_ff;
         pslverr_ff <= PSEL && PENABLE && !pready_ff && !mapped;
         if (PSEL && PENABLE && !pready_ff && !PWRITE) begin
            prdata_ff <= sel_data ? {24'h000000, data_ff} :
                         sel_ctrl ? {24'h000000, ctrl_rd} :
                         sel_ie ? {31'h0000_0000, ie_ff} : 32'h0000_0000;
         end
      end
   end

   // pin mux; port disabled gives the pins back to the general-purpose port
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pins_ff <= '0;
      end else if (ctrl_ff.en) begin
         pins_ff.o[PIN_SCLK] <= ctrl_ff.master ? sclk_ff : 1'b0;
         pins_ff.oe[PIN_SCLK] <= ctrl_ff.master;
         pins_ff.o[PIN_MOSI] <= out_bit_ff;
         pins_ff.oe[PIN_MOSI] <= ctrl_ff.master;
         pins_ff.o[PIN_MISO] <= out_bit_ff;
         pins_ff.oe[PIN_MISO] <= !ctrl_ff.master && !s_sel_n;
         pins_ff.o[PIN_SEL] <= 1'b0;
         pins_ff.oe[PIN_SEL] <= 1'b0;
      end else begin
         pins_ff.o <= GP_O;
         pins_ff.oe <= GP_OE;
      end
   end

   // shared vector: serial and two-wire requests merge onto one line
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (ctrl_ff.done && ie_ff) || I2C_IRQ;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         // matches the synchroniser reset, so no false edge follows reset
         sclk_prev_ff <= 1'b1;
         sel_prev_ff <= 1'b1;
      end else begin
         sclk_prev_ff <= s_sclk;
         sel_prev_ff <= s_sel_n;
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign PIN_O = pins_ff.o;
   assign PIN_OE = pins_ff.oe;
   assign GP_I = sync2_ff;
   assign IRQ = irq_ff;

   // checks
   logic [CW:0] tog_ff;
   always_ff @(posedge MCLK) begin
      if (SYS_RST || state_ff != ST_MRUN) begin
         tog_ff <= '0;
      end else if (tick) begin
         tog_ff <= tog_ff + (CW+1)'(1);
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   done_set_a: assert property (xfer_done |=> ctrl_ff.done)
      else $error("done flag not set after byte");
   read_clear_a: assert property (data_rd && !xfer_done |=> !ctrl_ff.done)
      else $error("data read did not clear done");
   collision_a: assert property (data_wr && busy && !xfer_done |=>
      ctrl_ff.write_collision_flag && $stable(data_ff))
      else $error("collision not flagged or data disturbed");
   burst_len_a: assert property (m_done |-> tog_ff == (CW+1)'(2 * BYTE_BITS - 1))
      else $error("master burst not eight periods");
   idle_level_a: assert property (state_ff == ST_IDLE ##1 state_ff == ST_IDLE |->
      sclk_ff == $past(ctrl_ff.clock_idle_polarity))
      else $error("clock not at idle level");
   reset_val_a: assert property ($past(SYS_RST) |-> ctrl_ff == ssp_ctrl_t'(CTRL_RST))
      else $error("control reset value wrong");
   gp_pass_a: assert property (!ctrl_ff.en |=> PIN_OE == $past(GP_OE))
      else $error("disabled port does not pass pins");
   master_oe_a: assert property (ctrl_ff.en && ctrl_ff.master |=> PIN_OE[PIN_SCLK])
      else $error("master clock pin not driven");
   irq_out_a: assert property (ctrl_ff.done && ie_ff |=> IRQ)
      else $error("enabled done flag gives no irq");
   tick_rate_a: assert property (tick |-> ##1 !tick [*1] or (half_m1 == 4'h0))
      else $error("rate divider ticks too fast");
   done_hold_a: assert property (ctrl_ff.done && !data_rd && !ctrl_wr |=> ctrl_ff.done)
      else $error("done flag lost without a clear");
   write_collision_flag_hold_a: assert property (ctrl_ff.write_collision_flag && !ctrl_wr |=> ctrl_ff.write_collision_flag)
      else $error("collision flag cleared by hardware");
   slave_clk_a: assert property (ctrl_ff.en && !ctrl_ff.master |=> !PIN_OE[PIN_SCLK])
      else $error("slave drives the clock pin");
   miso_release_a: assert property (ctrl_ff.en && !ctrl_ff.master && s_sel_n |=>
      !PIN_OE[PIN_MISO])
      else $error("deselected slave drives its data pin");

   master_byte_c: cover property (m_done);
   master_ph1_c: cover property (m_done && ctrl_ff.clock_phase_select);
   slave_byte_c: cover property (s_done && !ctrl_ff.clock_phase_select);
   slave_ph1_c: cover property (s_done && ctrl_ff.clock_phase_select);
   collide_c: cover property (data_wr && busy);
endmodule : ssp_port

/* File: ssp_far_model.sv */
// far-side serial device: slave to our master, or master to our slave
// assumes the bench resolves pin levels and shares the core clock
module ssp_far_model import ssp_pkg::*; (
   input wire logic clk,
   input wire logic [PIN_N-1:0] pin,
   input wire logic role_m,
   input wire logic clock_idle_polarity,
   input wire logic clock_phase_select,
   output logic [PIN_N-1:0] o,
   output logic [PIN_N-1:0] oe,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh_ff;
   logic [7:0] rx_ff;
   logic drv_ff;
   logic prev_ff;
   logic tog_ff = 1'b0;
   logic sel_n_ff = 1'b1;
   logic bit_out;
   logic bit_in;
   // same polarity and phase as the port
   assign bit_out = clock_phase_select ? drv_ff : sh_ff[7];
   assign bit_in = role_m ? pin[PIN_MISO] : pin[PIN_MOSI];
   // clock rests at idle level outside frames
   assign o = {sel_n_ff, bit_out, bit_out, clock_idle_polarity ^ tog_ff};
   assign oe = {1'b1, !role_m, role_m, role_m};
   assign rx = rx_ff;
   // acts on the falling core edge so an answer is settled before the port samples
   always @(negedge clk) begin
      prev_ff <= pin[PIN_SCLK];
      if (pin[PIN_SCLK] !== prev_ff) begin
         if ((pin[PIN_SCLK] !== clock_idle_polarity) ^ clock_phase_select) begin
            rx_ff <= {rx_ff[6:0], bit_in};
         end else begin
            drv_ff <= sh_ff[7];
            sh_ff <= {sh_ff[6:0], 1'b0};
         end
      end
   end
   task automatic ld(input logic [7:0] b);
      sh_ff = b;
      rx_ff = 8'h00;
   endtask : ld
   task automatic sel(input logic v);
      sel_n_ff <= v;
   endtask : sel
   // half period kept at 4 cycles or more for the port's synchronisers
   task automatic burst(input int half);
      repeat (half) @(posedge clk);
      repeat (16) begin
         tog_ff <= ~tog_ff;
         repeat (half) @(posedge clk);
      end
   endtask : burst
endmodule : ssp_far_model

/* File: ssp_port_tb.sv */
// self-checking bench: registers over APB, master and slave bursts
// assumes the far device model and one core clock of 40 ns
module ssp_port_tb import ssp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [ADDR_W-1:0] A_DATA = {IDX_DATA, 2'b00};
   localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] A_IE = {IDX_IE, 2'b00};
   logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, I2C_IRQ, IRQ;
   logic [ADDR_W-1:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rdv;
   logic [PIN_N-1:0] PIN_I, PIN_O, PIN_OE, GP_O, GP_OE, GP_I, m_o, m_oe;
   logic [7:0] m_rx, fb, tx;
   logic [1:0] mode, rate;
   logic role_m, m_clock_idle_polarity, m_clock_phase_select, pat, sck_q, slv;
   int cyc, edges, t0, t1, bad_count, check_count;
   ssp_port ssp_port_inst (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .GP_O(GP_O),
      .GP_OE(GP_OE), .GP_I(GP_I), .I2C_IRQ(I2C_IRQ), .IRQ(IRQ));
   ssp_far_model far (.clk(MCLK), .pin(PIN_I), .role_m(role_m), .clock_idle_polarity(m_clock_idle_polarity),
      .clock_phase_select(m_clock_phase_select), .o(m_o), .oe(m_oe), .rx(m_rx));
   // undriven lines toggle so a stale level never passes
   always_comb begin
      for (int k = 0; k < PIN_N; k++) begin
         PIN_I[k] = PIN_OE[k] ? PIN_O[k] : (m_oe[k] ? m_o[k] : pat);
      end
   end
   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      pat <= ~pat;
      sck_q <= PIN_O[0];
      if (PIN_OE[0] === 1'b1 && PIN_O[0] !== sck_q) begin
         edges <= edges + 1;
         t1 <= cyc;
         if (edges == 0) t0 <= cyc;
      end
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one idle edge after release so setup never lands in the same step
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rdv = PRDATA;
      slv = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask : apb
   task automatic wait_done;
      do apb(1'b0, A_CTRL, 32'h0); while (rdv[7] !== 1'b1);
   endtask : wait_done
   initial begin
      {SYS_RST, PSEL, PENABLE, PWRITE, I2C_IRQ, role_m, m_clock_idle_polarity, m_clock_phase_select} = 8'h80;
      {PADDR, PWDATA, GP_O, GP_OE} = '0;
      {cyc, edges, t0, t1, bad_count, check_count} = '0;
      pat = 1'b0;
      repeat (5) @(posedge MCLK);
      SYS_RST <= 1'b0;
      @(posedge MCLK);
      apb(1'b0, A_CTRL, 32'h0);
      chk(rdv, 32'h05);
      apb(1'b0, A_DATA, 32'h0);
      chk(rdv, 32'h00);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, slv}, 32'h1);
      GP_OE <= 4'hA;
      GP_O <= 4'h5;
      repeat (4) @(posedge MCLK);
      chk({24'h0, PIN_OE, PIN_O}, 32'hA5);
      chk({30'h0, GP_I[3], GP_I[1]}, 32'h0);
      I2C_IRQ <= 1'b1;
      repeat (3) @(posedge MCLK);
      chk({31'h0, IRQ}, 32'h1);
      I2C_IRQ <= 1'b0;
      apb(1'b1, A_IE, 32'h1);
      for (int i = 0; i < 6; i++) begin
         mode = i[1:0];
         rate = (i < 4) ? 2'(2 + (i % 2)) : 2'(i - 4);
         fb = 8'hC3 ^ i[7:0];
         tx = 8'h5A + i[7:0];
         m_clock_idle_polarity <= mode[1];
         m_clock_phase_select <= mode[0];
         apb(1'b1, A_CTRL, {24'h0, 8'h30 | {4'h0, mode, rate}});
         far.sel(i[0]);
         repeat (3) @(posedge MCLK);
         // load only once the clock line rests at its new idle level
         far.ld(fb);
         edges = 0;
         chk({29'h0, PIN_OE[2:0]}, 32'h3);
         chk({31'h0, PIN_O[0]}, {31'h0, mode[1]});
         apb(1'b1, A_DATA, {24'h0, tx});
         apb(1'b1, A_DATA, 32'hFF);
         wait_done();
         chk({30'h0, rdv[7:6]}, 32'h3);
         chk({31'h0, IRQ}, 32'h1);
         chk(32'(edges), 32'd16);
         chk(32'(t1 - t0), 32'(15) << rate);
         chk({31'h0, PIN_O[0]}, {31'h0, mode[1]});
         chk({24'h0, m_rx}, {24'h0, tx});
         apb(1'b0, A_DATA, 32'h0);
         if (rate[1]) chk(rdv, {24'h0, fb});
         repeat (2) @(posedge MCLK);
         chk({31'h0, IRQ}, 32'h0);
         apb(1'b0, A_CTRL, 32'h0);
         chk({30'h0, rdv[7:6]}, 32'h1);
      end
      for (int j = 0; j < 4; j++) begin
         mode = j[1:0];
         fb = 8'h96 ^ j[7:0];
         tx = 8'h3C + j[7:0];
         m_clock_idle_polarity <= mode[1];
         m_clock_phase_select <= mode[0];
         role_m <= 1'b1;
         apb(1'b1, A_CTRL, {24'h0, 8'h21 | {4'h0, mode, 2'b00}});
         far.ld(fb);
         apb(1'b1, A_DATA, {24'h0, tx});
         far.sel(1'b0);
         far.burst(6);
         repeat (6) @(posedge MCLK);
         chk({29'h0, PIN_OE[2:0]}, 32'h4);
         apb(1'b0, A_CTRL, 32'h0);
         chk({30'h0, rdv[7], rdv[0]}, {30'h0, mode[0], 1'b0});
         far.sel(1'b1);
         wait_done();
         chk({24'h0, m_rx}, {24'h0, tx});
         apb(1'b1, A_CTRL, {24'h0, 8'h21 | {4'h0, mode, 2'b00}});
         apb(1'b0, A_CTRL, 32'h0);
         chk({31'h0, rdv[7]}, 32'h0);
         apb(1'b0, A_DATA, 32'h0);
         chk(rdv, {24'h0, fb});
      end
      conclude();
   end
endmodule : ssp_port_tb
